// ---- verilog/swi_sleep_wake.sv ----
// Sleep entry and interrupt wake-up arbitration with APB status/control
//
// Overview of operation
// - A sleep request that finds an enabled flag already pending acts as a no-operation.
// - A no-operation sleep leaves the watchdog counter and prescaler uncleared.
// - A no-operation sleep leaves the timeout and power-down flags unchanged.
// - An enabled interrupt arriving during or after sleep ends sleep at once.
// - Full sleep entry and its interrupt wake-up both clear the watchdog and prescaler.
// - A fully executed sleep sets the timeout flag and clears the power-down flag.
// - The power-down flag stays set across a no-operation sleep so software can tell.
// - In crystal modes wake-up waits 1024 oscillator cycles before the core clock runs.
// - Wake-up with global interrupts on calls the service routine at 0004h.
// - Wake-up with global interrupts off resumes in-line after the sleep instruction.
// - The divided clock output is not driven in any crystal mode.
// - Any enabled pending flag wakes the device whatever the global enable; disabled never.
// - The instruction at sleep address plus one is prefetched and runs first on wake.
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "swi_consts.svh"
module swi_sleep_wake
    import swi_pkg::*;
#(
    parameter int NSRC     = 8,
    parameter int OST_CNT  = `SWI_OST_CYCLES
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic               pready,
    output logic [31:0]        prdata,
    output logic               pslverr,
    input  wire logic [NSRC-1:0] int_flag,
    input  wire logic          osc_tick,
    input  wire swi_core_req_s core_req,
    output swi_core_rsp_s      core_rsp,
    output logic               watchdog_clear,
    output logic               timeout_status_flag,
    output logic               power_down_status_flag,
    output logic               divided_clock_output,
    output logic               divided_clock_oe_n
);
    // Counter sized from the count, so a longer start-up wait still fits
    localparam int              OSTW     = $clog2(OST_CNT) + 1;
    localparam logic [OSTW-1:0] OST_LAST = OSTW'(OST_CNT - 1);
    logic               global_interrupt_enable_r;
    swi_osc_e           osc_mode_r;
    logic [NSRC-1:0]    int_enable_r;
    swi_state_e         st_r;
    logic [15:0]        pc_r;
    logic [OSTW-1:0]    ost_cnt_r;
    logic [1:0]         div_cnt_r;
    logic               pready_r;
    logic               pslverr_r;
    logic [31:0]        prdata_r;
    logic               tmo_r;
    logic               pwrdn_r;
    logic               wdog_clr_r;
    logic               divclk_r;
    logic               divclk_oe_n_r;
    swi_core_rsp_s      rsp_r;
    logic               pend;
    logic               xtal;
    logic               apb_acc;

    function automatic logic is_xtal(input swi_osc_e m);
        is_xtal = (m != SWI_OSC_OTHER);
    endfunction : is_xtal

    function automatic logic [15:0] pc_plus1(input logic [15:0] pc);
        pc_plus1 = pc + 16'h0001;
    endfunction : pc_plus1

    assign pend    = |(int_flag & int_enable_r);
    assign xtal    = is_xtal(osc_mode_r);
    assign apb_acc = psel & penable & ~pready_r;

    assign pready                 = pready_r;
    assign prdata                 = prdata_r;
    assign pslverr                = pslverr_r;
    assign core_rsp               = rsp_r;
    assign watchdog_clear         = wdog_clr_r;
    assign timeout_status_flag    = tmo_r;
    assign power_down_status_flag = pwrdn_r;
    assign divided_clock_output   = divclk_r;
    assign divided_clock_oe_n     = divclk_oe_n_r;

    // APB slave: one wait cycle, answer on the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= apb_acc;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            if (apb_acc) begin
                case (paddr)
                    `SWI_CTRL_OFS: begin
                        prdata_r[`SWI_CTRL_GLBEN_BIT] <= global_interrupt_enable_r;
                        prdata_r[`SWI_CTRL_OSC_LSB +: 2] <= osc_mode_r;
                        prdata_r[`SWI_CTRL_IEN_LSB +: NSRC] <= int_enable_r;
                    end
                    `SWI_STATUS_OFS: begin
                        prdata_r[`SWI_STAT_TMO_BIT] <= tmo_r;
                        prdata_r[`SWI_STAT_PWRDN_BIT] <= pwrdn_r;
                        prdata_r[`SWI_STAT_ST_LSB +: 2] <= st_r;
                        prdata_r[`SWI_STAT_PEND_LSB +: NSRC] <= int_flag & int_enable_r;
                    end
                    default: pslverr_r <= 1'b1;
                endcase
            end
        end
    end

    // Control register writes take effect with the answer edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_interrupt_enable_r <= 1'b0;
            osc_mode_r                <= SWI_OSC_OTHER;
            int_enable_r              <= '0;
        end else if (psel && penable && pready_r && pwrite && paddr == `SWI_CTRL_OFS) begin
            global_interrupt_enable_r <= pwdata[`SWI_CTRL_GLBEN_BIT];
            osc_mode_r                <= swi_osc_e'(pwdata[`SWI_CTRL_OSC_LSB +: 2]);
            int_enable_r              <= pwdata[`SWI_CTRL_IEN_LSB +: NSRC];
        end
    end

    // Sequencer; a request outside RUN is ignored since the core is stopped then
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r      <= SWI_ST_RUN;
            pc_r      <= 16'h0000;
            ost_cnt_r <= '0;
        end else begin
            case (st_r)
                SWI_ST_RUN: begin
                    if (core_req.sleep_req && !pend) begin
                        st_r <= SWI_ST_SLEEP;
                        pc_r <= core_req.sleep_pc;
                    end
                end
                SWI_ST_SLEEP: begin
                    ost_cnt_r <= '0;
                    if (pend) begin
                        st_r <= xtal ? SWI_ST_OST : SWI_ST_WAKE;
                    end
                end
                SWI_ST_OST: begin
                    if (osc_tick) begin
                        if (ost_cnt_r == OST_LAST) begin
                            st_r <= SWI_ST_WAKE;
                        end
                        ost_cnt_r <= ost_cnt_r + OSTW'(1);
                    end
                end
                SWI_ST_WAKE: st_r <= SWI_ST_RUN;
                default:     st_r <= SWI_ST_RUN;
            endcase
        end
    end

    // Status flags and watchdog clear pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmo_r      <= `SWI_TMO_RESET;
            pwrdn_r    <= `SWI_PWRDN_RESET;
            wdog_clr_r <= 1'b0;
        end else begin
            wdog_clr_r <= 1'b0;
            if (st_r == SWI_ST_RUN && core_req.sleep_req && !pend) begin
                tmo_r      <= 1'b1;
                pwrdn_r    <= 1'b0;
                wdog_clr_r <= 1'b1;
            end else if (st_r == SWI_ST_SLEEP && pend) begin
                wdog_clr_r <= 1'b1;
            end
            // No-operation path touches nothing here
        end
    end

    // Core response: clock gating and resume address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsp_r <= '{core_clk_en: 1'b1, resume_valid: 1'b0, resume_pc: 16'h0000,
                       isr_call: 1'b0, isr_pc: `SWI_ISR_VECTOR};
        end else begin
            rsp_r.resume_valid <= 1'b0;
            rsp_r.isr_call     <= 1'b0;
            rsp_r.isr_pc       <= `SWI_ISR_VECTOR;
            if (st_r == SWI_ST_RUN && core_req.sleep_req && pend) begin
                rsp_r.resume_valid <= 1'b1;
                rsp_r.resume_pc    <= pc_plus1(core_req.sleep_pc);
            end else if (st_r == SWI_ST_RUN && core_req.sleep_req) begin
                rsp_r.core_clk_en <= 1'b0;
            end else if (st_r == SWI_ST_WAKE) begin
                rsp_r.core_clk_en  <= 1'b1;
                rsp_r.resume_valid <= 1'b1;
                rsp_r.resume_pc    <= pc_plus1(pc_r);
                rsp_r.isr_call     <= global_interrupt_enable_r;
            end
        end
    end

    // Divided clock output; crystal pins own the oscillator, so the output floats
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_r     <= 2'b00;
            divclk_r      <= 1'b0;
            divclk_oe_n_r <= 1'b1;
        end else begin
            divclk_oe_n_r <= xtal;
            if (div_cnt_r == 2'(`SWI_CLKDIV_HALF - 1)) begin
                div_cnt_r <= 2'b00;
                divclk_r  <= ~divclk_r;
            end else begin
                div_cnt_r <= div_cnt_r + 2'b01;
            end
        end
    end

    logic sreq_run;
    assign sreq_run = st_r == SWI_ST_RUN && core_req.sleep_req;

    nop_resume_a: assert property (@(posedge pclk) disable iff (!presetn)
        sreq_run && pend |=> rsp_r.resume_valid && st_r == SWI_ST_RUN
            && rsp_r.resume_pc == pc_plus1($past(core_req.sleep_pc)))
        else $error("no-operation sleep did not resume in-line");
    nop_no_wdog_a: assert property (@(posedge pclk) disable iff (!presetn)
        sreq_run && pend |=> !wdog_clr_r)
        else $error("watchdog cleared on no-operation sleep");
    nop_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
        sreq_run && pend |=> tmo_r == $past(tmo_r) && pwrdn_r == $past(pwrdn_r))
        else $error("status flags changed on no-operation sleep");
    pwrdn_kept_a: assert property (@(posedge pclk) disable iff (!presetn)
        sreq_run && pend && pwrdn_r |=> pwrdn_r)
        else $error("power-down flag lost on no-operation sleep");
    entry_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
        sreq_run && !pend |=> st_r == SWI_ST_SLEEP && tmo_r && !pwrdn_r && wdog_clr_r
            && !rsp_r.core_clk_en)
        else $error("full sleep entry wrong");
    wake_now_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_r == SWI_ST_SLEEP && pend |=> st_r != SWI_ST_SLEEP && wdog_clr_r)
        else $error("enabled interrupt did not wake");
    no_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_r == SWI_ST_SLEEP && !pend |=> st_r == SWI_ST_SLEEP)
        else $error("woke without enabled pending interrupt");
    ost_done_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_r == SWI_ST_OST && osc_tick && ost_cnt_r == OST_LAST
            |=> st_r == SWI_ST_WAKE ##1 rsp_r.core_clk_en)
        else $error("start-up wait did not end on its count");
    no_ost_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_r == SWI_ST_SLEEP && pend && !xtal |=> st_r == SWI_ST_WAKE)
        else $error("start-up wait applied outside crystal mode");
    isr_vec_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_r == SWI_ST_WAKE |=> rsp_r.isr_call == $past(global_interrupt_enable_r)
            && rsp_r.isr_pc == `SWI_ISR_VECTOR && rsp_r.resume_pc == pc_plus1(pc_r))
        else $error("wake-up resume or vector wrong");
    divclk_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        xtal ##1 xtal |-> divclk_oe_n_r)
        else $error("divided clock driven in crystal mode");
    divclk_on_a: assert property (@(posedge pclk) disable iff (!presetn)
        !xtal ##1 !xtal |-> !divclk_oe_n_r)
        else $error("divided clock not driven outside crystal mode");
    clk_gated_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_r == SWI_ST_SLEEP || st_r == SWI_ST_OST |-> !rsp_r.core_clk_en)
        else $error("core clock running during sleep or start-up wait");
    ost_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_r == SWI_ST_OST && !(osc_tick && ost_cnt_r == OST_LAST)
            |=> st_r == SWI_ST_OST)
        else $error("start-up wait ended early");
    isr_only_a: assert property (@(posedge pclk) disable iff (!presetn)
        rsp_r.isr_call |-> rsp_r.resume_valid && rsp_r.isr_pc == `SWI_ISR_VECTOR)
        else $error("service call without resume or at wrong vector");

    // Bus checks; a missed answer would hang the core's register accesses
    apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        apb_acc |=> pready_r)
        else $error("register access not answered");
    apb_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        apb_acc && paddr != `SWI_CTRL_OFS && paddr != `SWI_STATUS_OFS
            |=> pslverr_r && prdata_r == 32'h0000_0000)
        else $error("unmapped access not refused");
    ctrl_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pready_r && pwrite && paddr == `SWI_CTRL_OFS
            |=> int_enable_r == $past(pwdata[`SWI_CTRL_IEN_LSB +: NSRC]))
        else $error("control write lost");
    stat_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        apb_acc && !pwrite && paddr == `SWI_STATUS_OFS
            |=> prdata_r[`SWI_STAT_PWRDN_BIT] == $past(pwrdn_r))
        else $error("status read shows wrong power-down flag");

    nop_c: cover property (@(posedge pclk) disable iff (!presetn) sreq_run && pend);
    wake_c: cover property (@(posedge pclk) disable iff (!presetn)
        st_r == SWI_ST_SLEEP && pend && !xtal);
    ost_c: cover property (@(posedge pclk) disable iff (!presetn)
        st_r == SWI_ST_OST ##1 st_r == SWI_ST_WAKE);
    isr_c: cover property (@(posedge pclk) disable iff (!presetn)
        st_r == SWI_ST_WAKE && global_interrupt_enable_r);
    err_c: cover property (@(posedge pclk) disable iff (!presetn)
        pready_r && pslverr_r);
endmodule : swi_sleep_wake

// ---- verilog/swi_consts.svh ----
// Offsets, field positions, reset values and timing counts of the sleep/wake block
`ifndef SWI_CONSTS_SVH
`define SWI_CONSTS_SVH
`define SWI_CTRL_OFS        12'h000
`define SWI_STATUS_OFS      12'h004
`define SWI_CTRL_GLBEN_BIT  0
`define SWI_CTRL_OSC_LSB    1
`define SWI_CTRL_IEN_LSB    8
`define SWI_STAT_TMO_BIT    0
`define SWI_STAT_PWRDN_BIT  1
`define SWI_STAT_ST_LSB     2
`define SWI_STAT_PEND_LSB   8
`define SWI_TMO_RESET       1'b1
`define SWI_PWRDN_RESET     1'b1
`define SWI_OST_CYCLES      1024
`define SWI_ISR_VECTOR      16'h0004
`define SWI_CLKDIV_HALF     2
`endif

// ---- verilog/swi_pkg.sv ----
// Types shared by the sleep/wake block
package swi_pkg;
    typedef enum logic [1:0] {
        SWI_OSC_OTHER     = 2'b00,
        SWI_OSC_XTAL_LOW_POWER  = 2'b01,
        SWI_OSC_XTAL_MEDIUM     = 2'b10,
        SWI_OSC_XTAL_HIGH_SPEED = 2'b11
    } swi_osc_e;
    typedef enum logic [1:0] {
        SWI_ST_RUN   = 2'b00,
        SWI_ST_SLEEP = 2'b01,
        SWI_ST_OST   = 2'b10,
        SWI_ST_WAKE  = 2'b11
    } swi_state_e;
    typedef struct packed {
        logic        sleep_req;
        logic [15:0] sleep_pc;
    } swi_core_req_s;
    typedef struct packed {
        logic        core_clk_en;
        logic        resume_valid;
        logic [15:0] resume_pc;
        logic        isr_call;
        logic [15:0] isr_pc;
    } swi_core_rsp_s;
endpackage : swi_pkg

// ---- sim/swi_sleep_wake_tb.sv ----
// Self-checking bench for the sleep entry and interrupt wake-up block
`timescale 1ns/1ps
module swi_sleep_wake_tb;
    import swi_pkg::*;
    localparam int OST = 4;
    logic          pclk;
    logic          presetn;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [11:0]   paddr;
    logic [31:0]   pwdata;
    logic          pready;
    logic [31:0]   prdata;
    logic          pslverr;
    logic [7:0]    int_flag;
    logic          osc_tick;
    swi_core_req_s core_req;
    swi_core_rsp_s core_rsp;
    logic          watchdog_clear;
    logic          timeout_status_flag;
    logic          power_down_status_flag;
    logic          divided_clock_output;
    logic          divided_clock_oe_n;
    int            err_total;
    int            total_checks;
    int            seed;
    logic [31:0]   rd;
    logic          er;
    logic [7:0]    en;
    logic [15:0]   pc;
    logic [7:0]    dv;

    swi_sleep_wake #(.NSRC(8), .OST_CNT(OST)) u_swi_sleep_wake (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .int_flag(int_flag), .osc_tick(osc_tick),
        .core_req(core_req), .core_rsp(core_rsp), .watchdog_clear(watchdog_clear),
        .timeout_status_flag(timeout_status_flag),
        .power_down_status_flag(power_down_status_flag),
        .divided_clock_output(divided_clock_output),
        .divided_clock_oe_n(divided_clock_oe_n)
    );

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Resume address: the prefetched word after the sleep instruction
    function automatic logic [15:0] next_pc(input logic [15:0] p);
        next_pc = p + 16'h0001;
    endfunction : next_pc

    // Holds the request until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            close_out();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic sleep_req(input logic [15:0] p);
        @(posedge pclk);
        core_req <= '{sleep_req: 1'b1, sleep_pc: p};
        @(posedge pclk);
        core_req <= '0;
        #1;
    endtask : sleep_req

    // Full sleep, then wake by one enabled source; a disabled flag stays up meanwhile
    task automatic full_cycle(input logic global_interrupt_enable, input logic xtal);
        int n, wd, ticks;
        logic [7:0] src;
        n = 0; wd = 0; ticks = 0;
        @(posedge pclk);
        int_flag <= 8'h80;
        sleep_req(pc);
        chk(core_rsp.core_clk_en, 0);
        chk(watchdog_clear, 1);
        chk({timeout_status_flag, power_down_status_flag}, 2'b10);
        repeat (3) @(posedge pclk);
        #1 chk(core_rsp.core_clk_en, 0);
        // A random source may be disabled; fall back to one that is enabled
        src = en & (8'h01 << ($unsigned($random(seed)) % 7));
        if (src == 8'h00) src = 8'h01;
        @(posedge pclk);
        int_flag <= 8'h80 | src;
        do begin
            @(posedge pclk);
            if (osc_tick === 1'b1) ticks++;
            osc_tick <= xtal && !osc_tick;
            n++;
            #1;
            if (watchdog_clear === 1'b1) wd++;
        end while (core_rsp.resume_valid !== 1'b1 && n < 200);
        if (n >= 200) begin
            err_total++;
            close_out();
        end
        chk(wd, 1);
        chk(core_rsp.core_clk_en, 1);
        if (!xtal) chk(n, 2);
        if (xtal) chk(ticks, OST);
        if (xtal) chk(n, 2 * OST + 1);
        chk(core_rsp.resume_pc, next_pc(pc));
        chk(core_rsp.isr_call, global_interrupt_enable);
        chk(core_rsp.isr_pc, 16'h0004);
        chk({timeout_status_flag, power_down_status_flag}, 2'b10);
        @(posedge pclk);
        int_flag <= 8'h00;
        osc_tick <= 1'b0;
    endtask : full_cycle

    initial begin
        err_total = 0; total_checks = 0; seed = 7;
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0000_0000; int_flag = 8'h00;
        osc_tick = 1'b0; core_req = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        #1 chk({timeout_status_flag, power_down_status_flag, divided_clock_oe_n}, 3'b110);
        // Divided clock is pclk/4: each level lasts two cycles
        for (int i = 0; i < 8; i++) begin
            @(posedge pclk);
            #1 dv[i] = divided_clock_output;
        end
        chk(dv[5:0] ^ dv[7:2], 6'h3f);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk(er, 1'b1);
        chk(rd, 32'h0000_0000);
        $display("test reset_and_unmapped done");
        // No-operation sleep: an enabled flag already pending with global enable off
        en = 8'h7f & 8'($random(seed));
        en[0] = 1'b1;
        pc = 16'($random(seed));
        apb(1'b1, 12'h000, {16'h0000, en, 8'h00});
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk(rd, {16'h0000, en, 8'h00});
        int_flag <= 8'h01;
        sleep_req(pc);
        chk(core_rsp.resume_valid, 1);
        chk(core_rsp.resume_pc, next_pc(pc));
        chk(core_rsp.core_clk_en, 1);
        chk(watchdog_clear, 0);
        chk({timeout_status_flag, power_down_status_flag}, 2'b11);
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk(rd, 32'h0000_0103);
        @(posedge pclk);
        int_flag <= 8'h00;
        $display("test nop_sleep done");
        // Every oscillator mode, both global enable settings (on in modes 1 and 3, off in modes 0 and 2)
        for (int m = 0; m < 4; m++) begin
            pc = 16'($random(seed));
            apb(1'b1, 12'h000, {16'h0000, en, 5'b00000, m[1:0], m[0]});
            repeat (2) @(posedge pclk);
            #1 chk(divided_clock_oe_n, (m != 0));
            full_cycle(m[0], (m != 0));
            $display("test full_sleep mode %0d done", m);
        end
        close_out();
    end
endmodule : swi_sleep_wake_tb
